// ===== hdl/dldg_config.sv
// damping and second phase detector gain configuration registers
//
// What this block does
// - damping regs 8-bit RW, reset 0x13, analog gain [6:4], code [2:0].
// - code selects damping; 011 default gives 5; 000, 110, 111 invalid.
// - damping depends on bandwidth class per the 4/8/35/70 Hz table.
// - damping [6:4] sets low-reference analog gain when auto gain enabled.
// - secondary gain register RW, reset 0xc2: enable bit7, analog, digital.
// - high-ref analog gain needs auto enable; digital gain used in digital feedback mode, auto enable or not.
`timescale 1ns/100ps
module dldg_config import dldg_pkg::*; (
	input  wire logic       clk_i,                // 50 MHz system clock
	input  wire logic       reset_i,              // synchronous reset
	input  wire logic       sclk_i,               // serial port clock pin
	input  wire logic       cs_n_i,               // serial chip select
	input  wire logic       sdi_i,                // serial data in
	output logic            sdo_o,                // serial data out
	output logic            sdo_oe_o,             // sdo drive enable
	input  wire dldg_bw_t   main_bw_i,            // main loop bandwidth
	input  wire dldg_bw_t   sec_bw_i,             // secondary bandwidth
	input  wire logic       main_auto_gain_en_i,  // main auto gain enable
	input  wire logic       main_digital_fb_i,    // main digital feedback
	input  wire logic       main_ref_high_i,      // main ref above 8 kHz
	input  wire logic       sec_digital_fb_i,     // secondary digital fb
	input  wire logic       sec_ref_high_i,       // secondary ref > 8 kHz
	output logic      [7:0] main_damping_o,       // factor in tenths
	output logic            main_damping_valid_o, // code is valid
	output logic      [7:0] sec_damping_o,        // factor in tenths
	output logic            sec_damping_valid_o,  // code is valid
	output logic      [2:0] main_pd_gain_o,       // main detector gain
	output logic            main_pd_gain_used_o,  // main gain applies
	output logic      [2:0] sec_pd_gain_o,        // secondary gain
	output logic            sec_pd_gain_used_o    // secondary gain applies
);

	// =====================================================================
	// damping lookup: returns {valid, factor in tenths}
	function automatic logic [8:0] damp_lookup(input logic [2:0] code,
		input dldg_bw_t bw);
		logic [7:0] f;
		f = DAMP_5;
		case (code)
			3'h1: begin
				f = (bw == DLDG_BW_LE4) ? DAMP_5 :
					(bw == DLDG_BW_8) ? DAMP_2P5 : DAMP_1P2;
			end
			3'h2: begin
				f = (bw == DLDG_BW_35 || bw == DLDG_BW_70) ?
					DAMP_2P5 : DAMP_5;
			end
			3'h3: begin
				f = DAMP_5;
			end
			3'h4: begin
				f = (bw == DLDG_BW_35 || bw == DLDG_BW_70) ?
					DAMP_10 : DAMP_5;
			end
			3'h5: begin
				f = (bw == DLDG_BW_70) ? DAMP_20 :
					(bw == DLDG_BW_35) ? DAMP_10 : DAMP_5;
			end
			default: begin
				// unused codes: flag invalid, keep a harmless factor
				return {1'b0, DAMP_5};
			end
		endcase
		return {1'b1, f};
	endfunction

	// =====================================================================
	// registers and serial port
	logic [7:0] sec_damp_cfg;
	logic [7:0] main_damp_cfg;
	logic [7:0] sec_gain_cfg;
	logic [6:0] addr;
	logic [7:0] wr_data;
	logic       wr_en;
	logic [7:0] rd_data;

	dldg_serial_port u_port (
		.clk_i     (clk_i),
		.reset_i   (reset_i),
		.sclk_i    (sclk_i),
		.cs_n_i    (cs_n_i),
		.sdi_i     (sdi_i),
		.rd_data_i (rd_data),
		.addr_o    (addr),
		.wr_data_o (wr_data),
		.wr_en_o   (wr_en),
		.sdo_o     (sdo_o),
		.sdo_oe_o  (sdo_oe_o)
	);

	wire wr_sec_damp = wr_en && addr == SEC_DAMP_ADDR;
	wire wr_main_damp = wr_en && addr == MAIN_DAMP_ADDR;
	wire wr_sec_gain = wr_en && addr == SEC_GAIN_ADDR;

	// unmapped addresses read as zero
	assign rd_data = (addr == SEC_DAMP_ADDR) ? sec_damp_cfg :
		(addr == MAIN_DAMP_ADDR) ? main_damp_cfg :
		(addr == SEC_GAIN_ADDR) ? sec_gain_cfg : 8'h00;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sec_damp_cfg <= DAMP_RESET;
			main_damp_cfg <= DAMP_RESET;
			sec_gain_cfg <= GAIN_RESET;
		end else begin
			// unused bits are held at zero so they read back as zero
			if (wr_sec_damp) begin
				sec_damp_cfg <= wr_data & DAMP_MASK;
			end
			if (wr_main_damp) begin
				main_damp_cfg <= wr_data & DAMP_MASK;
			end
			if (wr_sec_gain) begin
				sec_gain_cfg <= wr_data & GAIN_MASK;
			end
		end
	end

	// =====================================================================
	// field decode
	wire [2:0] main_damping_code = main_damp_cfg[CODE_MSB:CODE_LSB];
	wire [2:0] secondary_damping_code = sec_damp_cfg[CODE_MSB:CODE_LSB];
	wire [2:0] main_low_ref_analog_gain = main_damp_cfg[ANA_MSB:ANA_LSB];
	wire [2:0] secondary_low_ref_analog_gain =
		sec_damp_cfg[ANA_MSB:ANA_LSB];
	wire secondary_auto_gain_enable = sec_gain_cfg[AUTO_EN_BIT];
	wire [2:0] secondary_high_ref_analog_gain =
		sec_gain_cfg[ANA_MSB:ANA_LSB];
	wire [2:0] secondary_digital_feedback_gain =
		sec_gain_cfg[CODE_MSB:CODE_LSB];

	wire [8:0] main_damp = damp_lookup(main_damping_code, main_bw_i);
	wire [8:0] sec_damp = damp_lookup(secondary_damping_code, sec_bw_i);

	// main loop: only the low-reference analog gain lives here
	wire main_gain_used = !main_digital_fb_i && main_auto_gain_en_i &&
		!main_ref_high_i;

	// secondary: digital gain applies in digital feedback mode with or without auto gain, analog only with auto gain
	wire [2:0] sec_ana_gain = sec_ref_high_i ?
		secondary_high_ref_analog_gain : secondary_low_ref_analog_gain;
	wire [2:0] next_sec_gain = sec_digital_fb_i ?
		secondary_digital_feedback_gain : sec_ana_gain;
	wire next_sec_used = sec_digital_fb_i || secondary_auto_gain_enable;

	// =====================================================================
	// registered outputs
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			main_damping_o <= DAMP_5;
			main_damping_valid_o <= 1'b0;
			sec_damping_o <= DAMP_5;
			sec_damping_valid_o <= 1'b0;
			main_pd_gain_o <= 3'h0;
			main_pd_gain_used_o <= 1'b0;
			sec_pd_gain_o <= 3'h0;
			sec_pd_gain_used_o <= 1'b0;
		end else begin
			main_damping_o <= main_damp[7:0];
			main_damping_valid_o <= main_damp[8];
			sec_damping_o <= sec_damp[7:0];
			sec_damping_valid_o <= sec_damp[8];
			main_pd_gain_o <= main_low_ref_analog_gain;
			main_pd_gain_used_o <= main_gain_used;
			sec_pd_gain_o <= next_sec_gain;
			sec_pd_gain_used_o <= next_sec_used;
		end
	end

	// =====================================================================
	// checks
	a_reset_values: assert property (@(posedge clk_i)
		reset_i |=> sec_damp_cfg == 8'h13 && main_damp_cfg == 8'h13)
		else $error("damping registers not at reset value");

	a_gain_reset: assert property (@(posedge clk_i)
		reset_i |=> sec_gain_cfg == 8'hc2)
		else $error("gain register not at reset value");

	a_damp_write: assert property (@(posedge clk_i)
		disable iff (reset_i)
		wr_en && addr == 7'h6b |=> main_damp_cfg == ($past(wr_data) & 8'h77))
		else $error("main damping write not stored");

	a_invalid_code: assert property (@(posedge clk_i)
		disable iff (reset_i)
		(main_damping_code == 3'h0 || main_damping_code > 3'h5)
		|=> !main_damping_valid_o)
		else $error("unused damping code reported valid");

	a_damp_70hz: assert property (@(posedge clk_i)
		disable iff (reset_i)
		sec_bw_i == DLDG_BW_70 && secondary_damping_code == 3'h5
		|=> sec_damping_o == 8'hc8 && sec_damping_valid_o)
		else $error("70 Hz code 5 damping not 20");

	a_damp_low_bw: assert property (@(posedge clk_i)
		disable iff (reset_i)
		main_bw_i == DLDG_BW_LE4 && main_damp[8] |=> main_damping_o == 8'h32)
		else $error("low bandwidth damping not 5");

	a_low_ref_gain: assert property (@(posedge clk_i)
		disable iff (reset_i)
		!sec_digital_fb_i && !sec_ref_high_i && secondary_auto_gain_enable
		|=> sec_pd_gain_used_o && sec_pd_gain_o == $past(sec_damp_cfg[6:4]))
		else $error("low reference analog gain not applied");

	a_auto_off: assert property (@(posedge clk_i)
		disable iff (reset_i)
		!sec_digital_fb_i && !secondary_auto_gain_enable
		|=> !sec_pd_gain_used_o)
		else $error("analog gain used with auto gain disabled");

	a_digital_gain: assert property (@(posedge clk_i)
		disable iff (reset_i)
		sec_digital_fb_i |=> sec_pd_gain_used_o &&
		sec_pd_gain_o == $past(sec_gain_cfg[2:0]))
		else $error("digital gain not applied");

endmodule

// ===== pkg/dldg_pkg.sv
// package: register map, field layout and damping encodings
package dldg_pkg;

	// =====================================================================
	// register map (serial port addresses)
	localparam logic [6:0] SEC_DAMP_ADDR = 7'h6a;
	localparam logic [6:0] MAIN_DAMP_ADDR = 7'h6b;
	localparam logic [6:0] SEC_GAIN_ADDR = 7'h6c;

	// =====================================================================
	// reset values and writable-bit masks
	localparam logic [7:0] DAMP_RESET = 8'h13;
	localparam logic [7:0] GAIN_RESET = 8'hc2;
	localparam logic [7:0] DAMP_MASK = 8'h77;
	localparam logic [7:0] GAIN_MASK = 8'hf7;

	// =====================================================================
	// field positions
	localparam int AUTO_EN_BIT = 7;
	localparam int ANA_MSB = 6;
	localparam int ANA_LSB = 4;
	localparam int CODE_MSB = 2;
	localparam int CODE_LSB = 0;

	// =====================================================================
	// serial frame: 1 read flag, 7 address bits, 8 data bits
	localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
	localparam logic [4:0] FRAME_LAST_BIT = 5'h0f;

	// =====================================================================
	// loop bandwidth classes and damping factors in tenths
	typedef enum logic [1:0] {
		DLDG_BW_LE4,
		DLDG_BW_8,
		DLDG_BW_35,
		DLDG_BW_70
	} dldg_bw_t;

	localparam logic [7:0] DAMP_1P2 = 8'h0c;
	localparam logic [7:0] DAMP_2P5 = 8'h19;
	localparam logic [7:0] DAMP_5 = 8'h32;
	localparam logic [7:0] DAMP_10 = 8'h64;
	localparam logic [7:0] DAMP_20 = 8'hc8;

endpackage

// ===== hdl/dldg_serial_port.sv
// serial configuration port slave: frames in, register strobes out
`timescale 1ns/100ps
module dldg_serial_port import dldg_pkg::*; (
	input  wire logic       clk_i,      // system clock
	input  wire logic       reset_i,    // synchronous reset
	input  wire logic       sclk_i,     // serial clock pin
	input  wire logic       cs_n_i,     // chip select pin, low active
	input  wire logic       sdi_i,      // serial data in pin
	input  wire logic [7:0] rd_data_i,  // read data for addr_o
	output logic      [6:0] addr_o,     // register address
	output logic      [7:0] wr_data_o,  // write data
	output logic            wr_en_o,    // one-cycle write strobe
	output logic            sdo_o,      // serial data out
	output logic            sdo_oe_o    // sdo drive enable
);

	// =====================================================================
	// pin synchronisers
	logic [2:0] sclk_sr;
	logic [1:0] cs_sr;
	logic [1:0] sdi_sr;
	logic [14:0] shift;
	logic [7:0] out_shift;
	logic [4:0] bit_cnt;
	logic is_read;
	logic load_pending;

	wire sclk_rise = sclk_sr[1] & ~sclk_sr[2];
	wire sclk_fall = ~sclk_sr[1] & sclk_sr[2];
	wire selected = ~cs_sr[1];
	wire sdi_bit = sdi_sr[1];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sclk_sr <= 3'h0;
			cs_sr <= 2'h3;
			sdi_sr <= 2'h0;
		end else begin
			sclk_sr <= {sclk_sr[1:0], sclk_i};
			cs_sr <= {cs_sr[0], cs_n_i};
			sdi_sr <= {sdi_sr[0], sdi_i};
		end
	end

	// =====================================================================
	// frame engine: sample on rising sclk, drive on falling sclk
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			shift <= 15'h0;
			out_shift <= 8'h0;
			bit_cnt <= 5'h0;
			is_read <= 1'b0;
			load_pending <= 1'b0;
			addr_o <= 7'h0;
			wr_data_o <= 8'h0;
			wr_en_o <= 1'b0;
			sdo_o <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else begin
			wr_en_o <= 1'b0;
			load_pending <= 1'b0;
			sdo_oe_o <= selected;
			if (!selected) begin
				bit_cnt <= 5'h0;
			end else begin
				if (load_pending) begin
					out_shift <= rd_data_i;
				end
				if (sclk_rise) begin
					shift <= {shift[13:0], sdi_bit};
					bit_cnt <= bit_cnt + 5'h01;
					if (bit_cnt == ADDR_LAST_BIT) begin
						addr_o <= {shift[5:0], sdi_bit};
						is_read <= shift[6];
						load_pending <= 1'b1;
					end
					// a frame cut short never writes
					if (bit_cnt == FRAME_LAST_BIT && !is_read) begin
						wr_data_o <= {shift[6:0], sdi_bit};
						wr_en_o <= 1'b1;
					end
				end
				if (sclk_fall && bit_cnt > ADDR_LAST_BIT) begin
					sdo_o <= out_shift[7];
					out_shift <= {out_shift[6:0], 1'b0};
				end
			end
		end
	end

	// =====================================================================
	// checks
	sequence frame_end_write;
		selected && sclk_rise && bit_cnt == FRAME_LAST_BIT && !is_read;
	endsequence

	a_write_strobe_once: assert property (@(posedge clk_i)
		disable iff (reset_i) frame_end_write |=> wr_en_o ##1 !wr_en_o)
		else $error("write strobe not a single pulse after frame end");

endmodule

// ===== testbench/tb_dldg_config.sv
// self-checking bench for the damping and detector gain register block
`timescale 1ns/100ps
module tb_dldg_config import dldg_pkg::*; ;
	localparam int HALF = 6;
	logic       clk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       sclk_i = 1'b0;
	logic       cs_n_i = 1'b1;
	logic       sdi_i = 1'b0;
	logic       m_auto = 1'b0;
	logic       m_dig = 1'b0;
	logic       m_refh = 1'b0;
	logic       s_dig = 1'b0;
	logic       s_refh = 1'b0;
	dldg_bw_t   m_bw = DLDG_BW_LE4;
	dldg_bw_t   s_bw = DLDG_BW_LE4;
	logic       sdo_o;
	logic       sdo_oe_o;
	logic [7:0] m_damp;
	logic       m_valid;
	logic [7:0] s_damp;
	logic       s_valid;
	logic [2:0] m_gain;
	logic       m_used;
	logic [2:0] s_gain;
	logic       s_used;
	logic [7:0] q;
	int         miscompares = 0;
	int         n_compared = 0;
	// released line floats high, as with a pull-up
	wire        sdo_line = sdo_oe_o ? sdo_o : 1'b1;

	always #10 clk_i = ~clk_i;

	dldg_config dldg_config_inst (
		.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk_i),
		.cs_n_i(cs_n_i), .sdi_i(sdi_i), .sdo_o(sdo_o),
		.sdo_oe_o(sdo_oe_o), .main_bw_i(m_bw), .sec_bw_i(s_bw),
		.main_auto_gain_en_i(m_auto), .main_digital_fb_i(m_dig),
		.main_ref_high_i(m_refh), .sec_digital_fb_i(s_dig),
		.sec_ref_high_i(s_refh), .main_damping_o(m_damp),
		.main_damping_valid_o(m_valid), .sec_damping_o(s_damp),
		.sec_damping_valid_o(s_valid), .main_pd_gain_o(m_gain),
		.main_pd_gain_used_o(m_used), .sec_pd_gain_o(s_gain),
		.sec_pd_gain_used_o(s_used)
	);

	// =====================================================================
	// reporting
	task automatic finish_test;
		if (miscompares == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// =====================================================================
	// serial frames; n below 16 cuts the frame short
	task automatic xfer(input logic rd, input logic [6:0] a,
			input logic [7:0] d, input int n, output logic [7:0] r);
		logic [15:0] bits;
		bits = {rd, a, d};
		r = 8'h00;
		cs_n_i = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			sdi_i = bits[i];
			repeat (HALF) @(negedge clk_i);
			if (rd && i < 8) begin
				r[i] = sdo_line;
				chk({7'h0, sdo_oe_o}, 8'h01);
			end
			sclk_i = 1'b1;
			repeat (HALF) @(negedge clk_i);
			sclk_i = 1'b0;
		end
		repeat (HALF) @(negedge clk_i);
		cs_n_i = 1'b1;
		repeat (8) @(negedge clk_i);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer(1'b0, a, d, 16, r);
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] r);
		xfer(1'b1, a, 8'h00, 16, r);
	endtask

	// =====================================================================
	// expected damping factor in tenths; invalid codes read as 5
	function automatic logic [7:0] exp_damp(input dldg_bw_t bw,
			input logic [2:0] c);
		if (c == 3'h0 || c > 3'h5 || bw == DLDG_BW_LE4)
			return DAMP_5;
		if (bw == DLDG_BW_8)
			return (c == 3'h1) ? DAMP_2P5 : DAMP_5;
		case (c)
			3'h1: return DAMP_1P2;
			3'h2: return DAMP_2P5;
			3'h3: return DAMP_5;
			3'h4: return DAMP_10;
			default: return (bw == DLDG_BW_70) ? DAMP_20 : DAMP_10;
		endcase
	endfunction

	// =====================================================================
	// tests
	initial begin
		repeat (16) @(negedge clk_i);
		chk(s_damp, DAMP_5);
		chk({7'h0, s_valid}, 8'h00);
		reset_i = 1'b0;
		repeat (4) @(negedge clk_i);
		rd(SEC_DAMP_ADDR, q); chk(q, DAMP_RESET);
		rd(MAIN_DAMP_ADDR, q); chk(q, DAMP_RESET);
		rd(SEC_GAIN_ADDR, q); chk(q, GAIN_RESET);
		chk({7'h0, sdo_oe_o}, 8'h00);
		wr(SEC_DAMP_ADDR, 8'hff);
		wr(MAIN_DAMP_ADDR, 8'hff);
		wr(SEC_GAIN_ADDR, 8'hff);
		wr(7'h10, 8'h5a);
		rd(SEC_DAMP_ADDR, q); chk(q, DAMP_MASK);
		rd(MAIN_DAMP_ADDR, q); chk(q, DAMP_MASK);
		rd(SEC_GAIN_ADDR, q); chk(q, GAIN_MASK);
		rd(7'h10, q); chk(q, 8'h00);
		// a frame cut after ten bits must leave the register alone
		xfer(1'b0, MAIN_DAMP_ADDR, 8'h11, 10, q);
		rd(MAIN_DAMP_ADDR, q); chk(q, DAMP_MASK);
		for (int c = 0; c < 8; c++) begin
			wr(MAIN_DAMP_ADDR, 8'(c));
			wr(SEC_DAMP_ADDR, 8'(c));
			for (int b = 0; b < 4; b++) begin
				m_bw = dldg_bw_t'(b);
				s_bw = dldg_bw_t'(b);
				repeat (2) @(negedge clk_i);
				chk(m_damp, exp_damp(m_bw, 3'(c)));
				chk(s_damp, exp_damp(s_bw, 3'(c)));
				chk({7'h0, m_valid}, {7'h0, c >= 1 && c <= 5});
				chk({7'h0, s_valid}, {7'h0, c >= 1 && c <= 5});
			end
		end
		wr(MAIN_DAMP_ADDR, 8'h53);
		wr(SEC_DAMP_ADDR, 8'h63);
		for (int e = 0; e < 2; e++) begin
			wr(SEC_GAIN_ADDR, e ? 8'hb2 : 8'h32);
			for (int k = 0; k < 8; k++) begin
				{s_dig, s_refh, m_auto} = 3'(k);
				m_dig = s_dig;
				m_refh = s_refh;
				repeat (2) @(negedge clk_i);
				chk({5'h0, m_gain}, 8'h05);
				chk({7'h0, m_used}, {7'h0, !m_dig && m_auto && !m_refh});
				chk({5'h0, s_gain}, s_dig ? 8'h02 : (s_refh ? 8'h03 : 8'h06));
				chk({7'h0, s_used}, {7'h0, s_dig || e == 1});
			end
		end
		reset_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk({7'h0, m_valid}, 8'h00);
		reset_i = 1'b0;
		repeat (4) @(negedge clk_i);
		// 70 Hz loop, reset code 011, secondary still in digital mode
		chk(m_damp, DAMP_5);
		chk({7'h0, m_valid}, 8'h01);
		chk({5'h0, m_gain}, 8'h01);
		chk({5'h0, s_gain}, 8'h02);
		rd(MAIN_DAMP_ADDR, q); chk(q, DAMP_RESET);
		rd(SEC_GAIN_ADDR, q); chk(q, GAIN_RESET);
		finish_test();
	end

	// the run needs roughly 7300 cycles
	initial begin
		repeat (40000) @(posedge clk_i);
		miscompares++;
		finish_test();
	end
endmodule
